// >>> core/rdt_pkg.sv
// Constants, types and register map of the reloading down timer
package rdt_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 8;
	localparam int NREQ   = 2;

	// Byte addresses of the registers
	localparam logic [11:0] ADDR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_LATCH = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_REQ   = 12'h00C;
	localparam logic [11:0] ADDR_EN    = 12'h010;

	// Control field positions
	localparam int CTRL_STOP_BIT  = 0;
	localparam int CTRL_MODE_LSB  = 1;
	localparam int CTRL_EDGE_BIT  = 3;
	localparam int CTRL_LOW_BIT   = 4;
	localparam int CTRL_W         = 5;

	// Request and enable bit positions
	localparam int REQ_TIMER_BIT = 0;
	localparam int REQ_PIN_BIT   = 1;

	// Reset values
	localparam logic [4:0] CTRL_RST  = 5'h00;
	localparam logic [7:0] LATCH_RST = 8'hFF;
	localparam logic [7:0] COUNT_RST = 8'hFF;
	localparam logic [1:0] REQ_RST   = 2'h0;
	localparam logic [1:0] EN_RST    = 2'h0;

	// Oscillator edges per count tick
	localparam int          TICK_DIV   = 16;
	localparam int          PRE_W      = 4;
	localparam logic [3:0]  PRE_LAST   = 4'(TICK_DIV - 1);

	typedef enum logic [1:0] {
		MODE_TIMER  = 2'b00,
		MODE_PULSE  = 2'b01,
		MODE_EVENT  = 2'b10,
		MODE_PWIDTH = 2'b11
	} mode_e;

	typedef struct packed {
		logic  low_speed;
		logic  edge_sw;
		mode_e mode;
		logic  stop;
	} ctrl_s;

	typedef struct packed {
		logic pin;
		logic timer;
	} req_s;

endpackage : rdt_pkg

// >>> core/rdt_prescaler.sv
// Divide-by-16 count source from the main or sub oscillator
`timescale 1ns/1ps
`default_nettype none
module rdt_prescaler (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic main_oscillator_input,
	input  wire logic sub_oscillator_input,
	input  wire logic low_speed,
	output logic      tick
);
	logic                    main_prev_q;
	logic                    sub_prev_q;
	logic [rdt_pkg::PRE_W-1:0] div_q;
	logic                    tick_q;
	wire                     main_rise;
	wire                     sub_rise;
	wire                     src_rise;
	wire                     wrap;

	// Oscillator inputs are synchronous levels; count their rising edges
	assign main_rise = main_oscillator_input & ~main_prev_q;
	assign sub_rise  = sub_oscillator_input & ~sub_prev_q;
	assign src_rise  = low_speed ? sub_rise : main_rise;
	assign wrap      = src_rise & (div_q == rdt_pkg::PRE_LAST);
	assign tick      = tick_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_prev_q <= 1'b0;
			sub_prev_q  <= 1'b0;
			div_q       <= '0;
			tick_q      <= 1'b0;
		end else begin
			main_prev_q <= main_oscillator_input;
			sub_prev_q  <= sub_oscillator_input;
			if (src_rise) begin
				div_q <= div_q + 1'b1;
			end
			tick_q <= wrap;
		end
	end

endmodule : rdt_prescaler
`default_nettype wire

// >>> core/rdt_pulse_out.sv
// Toggling pulse output and its active-edge detector
`timescale 1ns/1ps
`default_nettype none
module rdt_pulse_out (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pulse_mode,
	input  wire logic edge_sw,
	input  wire logic underflow,
	output logic      pin_level,
	output logic      pin_edge
);
	logic level_q;
	logic mode_prev_q;
	logic edge_q;
	wire  entering;
	wire  toggle;
	wire  new_level;

	assign entering  = pulse_mode & ~mode_prev_q;
	assign toggle    = pulse_mode & ~entering & underflow;
	assign new_level = ~level_q;
	assign pin_level = level_q;
	assign pin_edge  = edge_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q     <= 1'b0;
			mode_prev_q <= 1'b0;
			edge_q      <= 1'b0;
		end else begin
			mode_prev_q <= pulse_mode;
			edge_q      <= 1'b0;
			if (entering) begin
				level_q <= edge_sw;
			end else if (toggle) begin
				level_q <= new_level;
				// Rising active when switch is one, falling when zero
				edge_q  <= (new_level == edge_sw);
			end
		end
	end

endmodule : rdt_pulse_out
`default_nettype wire

// >>> core/reload_down_timer_pulse_out.sv
// Reloading down timer with pulse output, APB register slave
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module reload_down_timer_pulse_out (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        main_oscillator_input,
	input  wire logic        sub_oscillator_input,
	input  wire logic        timer_accept,
	input  wire logic        pin_accept,
	output logic             timer_irq,
	output logic             pin_irq,
	output logic             shared_port_pin_out,
	output logic             shared_port_pin_oe
);

	// Register state
	rdt_pkg::ctrl_s          ctrl_q;
	rdt_pkg::ctrl_s          ctrl_d;
	logic [7:0]              latch_q;
	logic [7:0]              count_q;
	logic [7:0]              count_d;
	logic [1:0]              req_q;
	logic [1:0]              en_q;
	logic [31:0]             prdata_q;
	logic                    pslverr_q;

	// Bus decode
	wire                     setup;
	wire                     access;
	wire                     sel_ctrl;
	wire                     sel_latch;
	wire                     sel_count;
	wire                     sel_req;
	wire                     sel_en;
	wire                     hit;
	wire                     wr_lane0;
	wire                     wr_ctrl;
	wire                     wr_latch;
	wire                     wr_req;
	wire                     wr_en;
	wire [31:0]              rd_word;

	// Counting
	wire                     tick;
	wire                     run;
	wire                     at_zero;
	wire                     underflow;
	wire                     pulse_mode;
	wire                     pin_level;
	wire                     pin_edge;
	wire [1:0]               req_set;
	wire [1:0]               req_clr;
	wire [1:0]               req_ack;
	wire [1:0]               req_d;

	// -------------------------------------------------------------------
	// APB slave: zero wait states. Read data is captured at the setup
	// edge so that it leaves a flip-flop during the access phase.
	// -------------------------------------------------------------------
	assign setup     = psel & ~penable;
	assign access    = psel & penable;

	assign sel_ctrl  = (paddr == rdt_pkg::ADDR_CTRL);
	assign sel_latch = (paddr == rdt_pkg::ADDR_LATCH);
	assign sel_count = (paddr == rdt_pkg::ADDR_COUNT);
	assign sel_req   = (paddr == rdt_pkg::ADDR_REQ);
	assign sel_en    = (paddr == rdt_pkg::ADDR_EN);
	assign hit       = sel_ctrl | sel_latch | sel_count | sel_req | sel_en;

	// All fields live in byte lane 0; other lanes are ignored
	assign wr_lane0  = access & pwrite & pstrb[0];
	assign wr_ctrl   = wr_lane0 & sel_ctrl;
	assign wr_latch  = wr_lane0 & sel_latch;
	assign wr_req    = wr_lane0 & sel_req;
	assign wr_en     = wr_lane0 & sel_en;

	assign rd_word =
		sel_ctrl  ? {27'h0000000, ctrl_q} :
		sel_latch ? {24'h000000, latch_q} :
		sel_count ? {24'h000000, count_q} :
		sel_req   ? {30'h00000000, req_q} :
		sel_en    ? {30'h00000000, en_q} :
		32'h00000000;

	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= pwrite ? 32'h00000000 : rd_word;
			pslverr_q <= ~hit;
		end else if (!psel) begin
			pslverr_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------------
	// Control register
	// -------------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d.stop      = pwdata[rdt_pkg::CTRL_STOP_BIT];
			ctrl_d.mode      = rdt_pkg::mode_e'(
				pwdata[rdt_pkg::CTRL_MODE_LSB +: 2]);
			ctrl_d.edge_sw   = pwdata[rdt_pkg::CTRL_EDGE_BIT];
			ctrl_d.low_speed = pwdata[rdt_pkg::CTRL_LOW_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= rdt_pkg::ctrl_s'(rdt_pkg::CTRL_RST);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q <= rdt_pkg::LATCH_RST;
			en_q    <= rdt_pkg::EN_RST;
		end else begin
			if (wr_latch) begin
				latch_q <= pwdata[7:0];
			end
			if (wr_en) begin
				en_q <= pwdata[1:0];
			end
		end
	end

	// -------------------------------------------------------------------
	// Count source
	// -------------------------------------------------------------------
	rdt_prescaler u_prescaler (
		.pclk                  (pclk),
		.presetn               (presetn),
		.main_oscillator_input (main_oscillator_input),
		.sub_oscillator_input  (sub_oscillator_input),
		.low_speed             (ctrl_q.low_speed),
		.tick                  (tick)
	);

	// -------------------------------------------------------------------
	// Down counter. The event and pulse width modes are not built here;
	// selecting them counts as in timer mode but drives no pin.
	// -------------------------------------------------------------------
	assign run       = tick & ~ctrl_q.stop;
	assign at_zero   = (count_q == 8'h00);
	assign underflow = run & at_zero & ~wr_latch;

	always_comb begin
		count_d = count_q;
		if (wr_latch) begin
			// A write sets the initial value of both latch and counter
			count_d = pwdata[7:0];
		end else if (run) begin
			if (at_zero) begin
				count_d = latch_q;
			end else begin
				count_d = count_q - 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= rdt_pkg::COUNT_RST;
		end else begin
			count_q <= count_d;
		end
	end

	// -------------------------------------------------------------------
	// Pulse output on the shared pin
	// -------------------------------------------------------------------
	assign pulse_mode = (ctrl_q.mode == rdt_pkg::MODE_PULSE);

	rdt_pulse_out u_pulse_out (
		.pclk       (pclk),
		.presetn    (presetn),
		.pulse_mode (pulse_mode),
		.edge_sw    (ctrl_q.edge_sw),
		.underflow  (underflow),
		.pin_level  (pin_level),
		.pin_edge   (pin_edge)
	);

	// Pin level comes from a flop; the enable only follows the mode
	assign shared_port_pin_out = pin_level;
	assign shared_port_pin_oe  = pulse_mode;

	// -------------------------------------------------------------------
	// Request bits. A hardware set in the cycle of a clear wins, so an
	// underflow that lands on a software clear is never lost.
	// -------------------------------------------------------------------
	assign req_set[rdt_pkg::REQ_TIMER_BIT] = underflow;
	assign req_set[rdt_pkg::REQ_PIN_BIT]   = pin_edge & pulse_mode;
	assign req_ack[rdt_pkg::REQ_TIMER_BIT] = timer_accept;
	assign req_ack[rdt_pkg::REQ_PIN_BIT]   = pin_accept;

	genvar gi;
	generate
		for (gi = 0; gi < rdt_pkg::NREQ; gi++) begin : g_req
			// Writing zero clears; writing one leaves the bit alone
			assign req_clr[gi] = wr_req & ~pwdata[gi];
			assign req_d[gi]   = req_set[gi] |
				(req_q[gi] & ~req_clr[gi] & ~req_ack[gi]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= rdt_pkg::REQ_RST;
		end else begin
			req_q <= req_d;
		end
	end

	// Requests reach the controller only while enabled
	assign timer_irq = req_q[rdt_pkg::REQ_TIMER_BIT] &
		en_q[rdt_pkg::REQ_TIMER_BIT];
	assign pin_irq   = req_q[rdt_pkg::REQ_PIN_BIT] &
		en_q[rdt_pkg::REQ_PIN_BIT];

endmodule : reload_down_timer_pulse_out
`default_nettype wire

// >>> tb/rdt_pin_load.sv
// External load on the shared pin: resolves the wire and times its edges
`timescale 1ns/1ps
`default_nettype none
module rdt_pin_load (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic     level,
	output int       gap
);
	logic line_q;
	int   since_q;
	// No pull on the line: undriven it keeps moving so nobody trusts it
	assign level = pin_oe ? pin_out : !line_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_q <= 1'b0;
			since_q <= 0;
			gap <= 0;
		end else begin
			line_q <= level;
			if (pin_oe && level != line_q) begin
				gap <= since_q + 1;
				since_q <= 0;
			end else begin
				since_q <= since_q + 1;
			end
		end
	end
endmodule : rdt_pin_load
`default_nettype wire

// >>> tb/reload_down_timer_pulse_out_chk.sv
// Port-level assertions for the reloading down timer
`timescale 1ns/1ps
`default_nettype none
module rdt_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pslverr,
	input wire logic        timer_accept,
	input wire logic        pin_accept,
	input wire logic        timer_irq,
	input wire logic        pin_irq,
	input wire logic        shared_port_pin_out,
	input wire logic        shared_port_pin_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_go    = psel && penable && pwrite && pstrb[0];
	wire ctrl_wr  = wr_go && paddr == rdt_pkg::ADDR_CTRL;
	wire timer_wr = ctrl_wr && pwdata[2:1] == 2'b00;
	wire pulse_wr = ctrl_wr && pwdata[2:1] == 2'b01;
	wire mask_wr  = wr_go && paddr == rdt_pkg::ADDR_EN && pwdata[1:0] == 2'b00;
	wire bad_addr = paddr > 12'h010 || paddr[1:0] != 2'b00;
	sequence enter_pulse;
		pulse_wr && !shared_port_pin_oe;
	endsequence
	sequence start_level;
		shared_port_pin_oe ##1 shared_port_pin_out == $past(pwdata[3], 2);
	endsequence
	// Entry itself moves the pin, so only edges well inside the mode count
	sequence toggled;
		shared_port_pin_oe [*3] ##0 $changed(shared_port_pin_out);
	endsequence
	pulse_start_a: assert property (enter_pulse |=> start_level)
		else $error("pulse start level wrong");
	timer_off_a: assert property (timer_wr |=> !shared_port_pin_oe)
		else $error("pin still driven in timer mode");
	pulse_hold_a: assert property (toggled |=> $stable(shared_port_pin_out) [*8])
		else $error("pin toggled faster than a count tick");
	irq_mask_a: assert property (mask_wr |=> !timer_irq && !pin_irq)
		else $error("masked request still signalled");
	timer_ack_a: assert property (timer_accept && timer_irq && !$past(timer_irq, 3)
		|=> !timer_irq)
		else $error("timer request not cleared by accept");
	pin_ack_a: assert property (pin_accept && pin_irq && !$past(pin_irq, 3)
		|=> !pin_irq)
		else $error("pin request not cleared by accept");
	reset_out_a: assert property ($rose(presetn)
		|-> !shared_port_pin_oe && !timer_irq && !pin_irq)
		else $error("outputs active after reset");
	bad_addr_a: assert property (psel && penable && bad_addr |-> pslverr)
		else $error("unmapped access without error");
endmodule : rdt_chk
bind reload_down_timer_pulse_out rdt_chk rdt_chk_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .timer_accept,
	.pin_accept, .timer_irq, .pin_irq, .shared_port_pin_out,
	.shared_port_pin_oe);
`default_nettype wire

// >>> tb/reload_down_timer_pulse_out_tb.sv
// Register-level testbench for the reloading down timer
`timescale 1ns/1ps
`default_nettype none
module reload_down_timer_pulse_out_tb;
	logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [3:0]  pstrb;
	logic        main_oscillator_input = 1'b0;
	logic        sub_oscillator_input = 1'b0;
	logic        err, level;
	logic        timer_accept, pin_accept, timer_irq, pin_irq;
	logic        shared_port_pin_out, shared_port_pin_oe;
	logic [31:0] q1;
	int          fails, total_checks, n, gap;
	int          cyc = 0;
	reload_down_timer_pulse_out reload_down_timer_pulse_out_i (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .main_oscillator_input, .sub_oscillator_input,
		.timer_accept, .pin_accept, .timer_irq, .pin_irq,
		.shared_port_pin_out, .shared_port_pin_oe);
	rdt_pin_load rdt_pin_load_i (.pclk, .presetn, .pin_out(shared_port_pin_out),
		.pin_oe(shared_port_pin_oe), .level, .gap);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = !pclk;
	end
	// Main gives a rising edge every 2 cycles, sub every 4
	always @(posedge pclk) begin
		main_oscillator_input <= !main_oscillator_input;
		if (cyc[0]) sub_oscillator_input <= !sub_oscillator_input;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic chk_w(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk_w
	task automatic chk_b(input logic g, input logic x);
		chk_w({31'h0, g}, {31'h0, x});
	endtask : chk_b
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdq = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Counts edges since the previous detection, the accept edge included
	task automatic wait_t(output int k);
		k = 1;
		do begin
			@(posedge pclk);
			k++;
		end while (timer_irq !== 1'b1);
		timer_accept <= 1'b1;
		@(posedge pclk);
		timer_accept <= 1'b0;
	endtask : wait_t
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{timer_accept, pin_accept, fails, total_checks} = '0;
		pstrb = 4'hF;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(rdt_pkg::ADDR_CTRL);
		chk_w(rdq, 32'h0);
		rd(rdt_pkg::ADDR_LATCH);
		chk_w(rdq, 32'h000000FF);
		rd(12'h020);
		chk_b(err, 1'b1);
		for (int m = 0; m < 4; m++) begin
			wr(rdt_pkg::ADDR_CTRL, 32'(m * 2 + 1));
			rd(rdt_pkg::ADDR_CTRL);
			chk_w(rdq, 32'(m * 2 + 1));
		end
		wr(rdt_pkg::ADDR_LATCH, 32'h000000C8);
		rd(rdt_pkg::ADDR_COUNT);
		q1 = rdq;
		repeat (60) @(posedge pclk);
		rd(rdt_pkg::ADDR_COUNT);
		chk_w(rdq, q1);
		wr(rdt_pkg::ADDR_CTRL, 32'h0);
		rd(rdt_pkg::ADDR_COUNT);
		q1 = rdq;
		repeat (29) @(posedge pclk);
		rd(rdt_pkg::ADDR_COUNT);
		chk_w(rdq, q1 - 32'h1);
		wr(rdt_pkg::ADDR_REQ, 32'h0);
		wr(rdt_pkg::ADDR_EN, 32'h1);
		wr(rdt_pkg::ADDR_LATCH, 32'h3);
		wait_t(n);
		wait_t(n);
		chk_w(32'(n), 32'd128);
		wr(rdt_pkg::ADDR_CTRL, 32'h10);
		wr(rdt_pkg::ADDR_LATCH, 32'h2);
		wait_t(n);
		wait_t(n);
		chk_w(32'(n), 32'd192);
		wr(rdt_pkg::ADDR_EN, 32'h0);
		repeat (200) @(posedge pclk);
		wr(rdt_pkg::ADDR_CTRL, 32'h11);
		chk_b(timer_irq, 1'b0);
		wr(rdt_pkg::ADDR_EN, 32'h1);
		@(posedge pclk);
		chk_b(timer_irq, 1'b1);
		wr(rdt_pkg::ADDR_REQ, 32'h1);
		rd(rdt_pkg::ADDR_REQ);
		chk_w(rdq, 32'h1);
		wr(rdt_pkg::ADDR_REQ, 32'h0);
		wr(rdt_pkg::ADDR_REQ, 32'h3);
		rd(rdt_pkg::ADDR_REQ);
		chk_w(rdq, 32'h0);
		wr(rdt_pkg::ADDR_LATCH, 32'h3);
		wr(rdt_pkg::ADDR_EN, 32'h3);
		for (int e = 0; e < 2; e++) begin
			wr(rdt_pkg::ADDR_CTRL, 32'h1);
			// The mode write lands on the edge the task returns at
			@(posedge pclk);
			chk_b(shared_port_pin_oe, 1'b0);
			wr(rdt_pkg::ADDR_CTRL, 32'(e * 8 + 3));
			repeat (2) @(posedge pclk);
			chk_b(level, e[0]);
		end
		// Edge switch changes may leave a stale pin request behind
		wr(rdt_pkg::ADDR_REQ, 32'h0);
		wr(rdt_pkg::ADDR_CTRL, 32'h0A);
		do @(posedge pclk); while (pin_irq !== 1'b1);
		chk_b(level, 1'b1);
		chk_w(32'(gap), 32'd128);
		pin_accept <= 1'b1;
		@(posedge pclk);
		pin_accept <= 1'b0;
		@(posedge pclk);
		chk_b(pin_irq, 1'b0);
		test_done();
	end
endmodule : reload_down_timer_pulse_out_tb
`default_nettype wire
